// ### include/dpio_defs.vh
// register offsets, field positions, reset values for the dual port pin block
`ifndef DPIO_DEFS_VH
`define DPIO_DEFS_VH
`define DPIO_OFS_FIRST_DATA    5'h00
`define DPIO_OFS_FIRST_DIR     5'h04
`define DPIO_OFS_FIRST_PULLUP  5'h08
`define DPIO_OFS_CHANGE_EN     5'h0C
`define DPIO_OFS_SECOND_DATA   5'h10
`define DPIO_OFS_SECOND_DIR    5'h14
`define DPIO_OFS_IRQ_CTRL      5'h18
`define DPIO_OFS_OPTION        5'h1C
`define DPIO_OFS_LCD_CTRL      5'h08
`define DPIO_OFS_SEG_LOW       5'h0C
`define DPIO_OFS_SEG_MID       5'h10
`define DPIO_OFS_PERIPH        5'h14
`define DPIO_PAGE_MAIN         2'h0
`define DPIO_PAGE_LCD          2'h1
`define DPIO_RST_FIRST_DIR     8'hFF
`define DPIO_RST_FIRST_PULLUP  8'hFF
`define DPIO_RST_CHANGE_EN     4'h0
`define DPIO_RST_IRQ_CTRL      8'h00
`define DPIO_RST_OPTION        8'hFF
`define DPIO_RST_LCD_CTRL      8'h13
`define DPIO_RST_SEG           8'h00
`define DPIO_RST_SECOND_DIR    8'hFF
`define DPIO_RST_PERIPH        8'h00
`define DPIO_BIT_PULLUP_DIS_N  7
`define DPIO_BIT_EDGE_SEL      6
`define DPIO_BIT_LCD_EN        7
`define DPIO_BIT_BIAS_EN       4
`define DPIO_BIT_GIE           7
`define DPIO_BIT_PERIPHERAL_IRQ_ENABLE          6
`define DPIO_BIT_TIMER0_IRQ_ENABLE          5
`define DPIO_BIT_EXT_IE        4
`define DPIO_BIT_CHG_IE        3
`define DPIO_BIT_TIMER0_IRQ_FLAG          2
`define DPIO_BIT_EXT_IF        1
`define DPIO_BIT_CHG_IF        0
`define DPIO_BIT_CCP_OUT       0
`define DPIO_BIT_SDO_OUT       1
`define DPIO_BIT_DBG_OUT       2
`endif

// ### rtl/dpio_top.v
// dual 8-bit general-purpose pin port with lcd sharing and AXI4-Lite registers
// Functional notes
// [RULE1] second port: eight pins, latch and direction
// [RULE2] write updates latch; driven only when output
// [RULE3] direction 1 input tristate, 0 drives latch
// [RULE4] data read returns sampled pin levels
// [RULE5] first port direction resets to all ones
// [RULE6] first port pullup enables reset to ones
// [RULE7] change enable: upper four bits only
// [RULE8] interrupt control bits, reset zero, flag kept
// [RULE9] option: pullup disable bit7, edge bit6
// [RULE10] first port pin0 external edge interrupt
// [RULE11] lcd analog outputs on selected pins
// [RULE12] second port pins 0-2 lcd bias inputs
// [RULE13] bias select and read gating by multiplex
// [RULE14] lcd control resets to 0x13
// [RULE15] segment enables clear only on power reset
// [RULE16] second pin5 timer1 clock or capture/pwm
// [RULE17] second pin4 timer1 gate or serial out
// [RULE18] first pins 7/6 programming data/clock
// [RULE19] pullup off while pin is output; first pin 7 keeps its pullup while debugger_data_oe drives it
// [RULE20] lcd analog pins disable digital driver
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`include "dpio_defs.vh"
module dpio_top (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        por_rst,
  input  wire [4:0]  s_axi_awaddr,
  input  wire [1:0]  s_axi_awpage,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [4:0]  s_axi_araddr,
  input  wire [1:0]  s_axi_arpage,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [7:0]  first_pin_in,
  output wire [7:0]  first_pin_out,
  output wire [7:0]  first_pin_oe,
  output wire [7:0]  first_pin_pullup,
  input  wire [7:0]  second_pin_in,
  output wire [7:0]  second_pin_out,
  output wire [7:0]  second_pin_oe,
  output wire [7:0]  lcd_analog_sel_first,
  output wire [7:0]  lcd_analog_sel_second,
  output wire [2:0]  lcd_bias_input_sel,
  output wire        ext_irq_event,
  output wire        timer1_clock_in,
  output wire        timer1_gate_in,
  input  wire        capture_compare_pwm_one_out,
  output wire        capture_in,
  input  wire        serial_data_out,
  input  wire        debugger_data_out,
  input  wire        debugger_data_oe,
  output wire        serial_program_clock,
  output wire        serial_program_data,
  input  wire        timer0_overflow,
  output wire        irq_request
);
  reg  [7:0] first_port_latch;
  reg  [7:0] first_port_direction;
  reg  [7:0] first_port_pullup_enable;
  reg  [3:0] change_interrupt_enable;
  reg  [7:0] second_port_latch;
  reg  [7:0] second_port_direction;
  reg  [7:1] irq_ctrl_upper;
  reg        port_change_irq_flag;
  wire [7:0] interrupt_control;
  reg  [7:0] option_control;
  reg  [7:0] lcd_control;
  reg  [7:0] lcd_segment_enable_low;
  reg  [7:0] lcd_segment_enable_mid;
  reg  [7:0] periph_select;
  reg  [3:0] change_snapshot;
  reg        ext_pin_prev;
  reg        aw_held;
  reg        w_held;
  reg  [4:0] aw_addr;
  reg  [1:0] aw_page;
  reg  [31:0] w_data;
  reg  [3:0] w_strb;
  reg  [31:0] next_rdata;
  reg        next_rok;
  reg        wr_ok;
  wire       do_write;
  wire       do_read;
  wire       wr_main;
  wire       wr_lcd;
  wire       rd_main;
  wire       rd_lcd;
  wire [1:0] lcd_multiplex_select;
  wire       lcd_module_enable;
  wire       lcd_bias_input_enable;
  wire       mux_active;
  wire [7:0] first_read;
  wire [7:0] second_read;
  wire       ext_edge;
  wire       change_hit;
  wire       global_pullup_disable_n;
  wire       ext_irq_edge_select;

  assign lcd_multiplex_select    = lcd_control[1:0];
  assign lcd_module_enable       = lcd_control[`DPIO_BIT_LCD_EN];
  assign lcd_bias_input_enable   = lcd_control[`DPIO_BIT_BIAS_EN];
  assign mux_active              = (lcd_multiplex_select != 2'h0);
  assign global_pullup_disable_n = option_control[`DPIO_BIT_PULLUP_DIS_N];
  assign ext_irq_edge_select     = option_control[`DPIO_BIT_EDGE_SEL];
  // change flag lives in the power reset domain, the rest in the ordinary one
  assign interrupt_control       = {irq_ctrl_upper, port_change_irq_flag};

  // segment map: first port pins 0-3 seg 0-3, 6 seg14, 7 seg13; second port 3 seg6, 4 seg11, 5 seg10
  assign lcd_analog_sel_first = {lcd_segment_enable_mid[5], lcd_segment_enable_mid[6],
    {2{lcd_module_enable && mux_active}}, lcd_segment_enable_low[3:0]} &
    {8{lcd_module_enable}}; // RULE11
  assign lcd_analog_sel_second = {2'h0, lcd_segment_enable_mid[2], lcd_segment_enable_mid[3],
    lcd_segment_enable_low[6], 3'h0} & {8{lcd_module_enable}}; // RULE11
  assign lcd_bias_input_sel = {3{lcd_bias_input_enable && mux_active}}; // RULE12 RULE13

  // alternate drivers override the latch; lcd analog use kills the driver
  wire [7:0] first_drive_oe  = ~first_port_direction;
  wire [7:0] second_drive_oe = ~second_port_direction;
  assign first_pin_out = {debugger_data_oe ? debugger_data_out : first_port_latch[7],
    first_port_latch[6:0]}; // RULE18
  assign first_pin_oe  = {first_drive_oe[7] | debugger_data_oe, first_drive_oe[6:0]} &
    ~lcd_analog_sel_first; // RULE20
  assign second_pin_out = {second_port_latch[7:6],
    periph_select[`DPIO_BIT_CCP_OUT] ? capture_compare_pwm_one_out : second_port_latch[5],
    periph_select[`DPIO_BIT_SDO_OUT] ? serial_data_out : second_port_latch[4],
    second_port_latch[3:0]}; // RULE2 RULE16 RULE17
  assign second_pin_oe = second_drive_oe & ~lcd_analog_sel_second &
    ~{5'h00, lcd_bias_input_sel}; // RULE3 RULE20
  assign first_pin_pullup = first_port_pullup_enable & first_port_direction &
    {8{~global_pullup_disable_n}}; // RULE19

  assign serial_program_clock = first_pin_in[6]; // RULE18
  assign serial_program_data  = first_pin_in[7]; // RULE18
  assign timer1_clock_in      = second_pin_in[5]; // RULE16
  assign capture_in           = second_pin_in[5]; // RULE16
  assign timer1_gate_in       = second_pin_in[4]; // RULE17

  // bias pin1 digital read is blocked while lcd uses it
  assign first_read  = first_pin_in; // RULE4
  assign second_read = {second_pin_in[7:2],
    second_pin_in[1] & ~(lcd_module_enable && mux_active), second_pin_in[0]}; // RULE4 RULE13

  // ext interrupt edge on first pin 0; edge select 1 = rising
  assign ext_edge = ext_irq_edge_select ? (first_pin_in[0] & ~ext_pin_prev) :
                                          (~first_pin_in[0] & ext_pin_prev); // RULE10
  assign ext_irq_event = ext_edge;
  assign change_hit = |((first_pin_in[7:4] ^ change_snapshot) & change_interrupt_enable);
  assign irq_request = interrupt_control[`DPIO_BIT_GIE] &
    |(interrupt_control[5:3] & interrupt_control[2:0]);

  // axi write channel: address and data accepted independently
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign wr_main  = do_write & (aw_page == `DPIO_PAGE_MAIN) & w_strb[0];
  assign wr_lcd   = do_write & (aw_page == `DPIO_PAGE_LCD) & w_strb[0];
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_read = s_axi_arvalid & ~s_axi_rvalid;
  assign rd_main = do_read & (s_axi_arpage == `DPIO_PAGE_MAIN);
  assign rd_lcd  = do_read & (s_axi_arpage == `DPIO_PAGE_LCD);

  always @* begin
    wr_ok = 1'b0;
    if (aw_page == `DPIO_PAGE_MAIN) begin
      wr_ok = 1'b1;
    end else if (aw_page == `DPIO_PAGE_LCD) begin
      wr_ok = (aw_addr == `DPIO_OFS_LCD_CTRL) || (aw_addr == `DPIO_OFS_SEG_LOW) ||
              (aw_addr == `DPIO_OFS_SEG_MID) || (aw_addr == `DPIO_OFS_PERIPH);
    end
  end

  always @* begin
    next_rdata = 32'h0000_0000;
    next_rok   = 1'b1;
    if (s_axi_arpage == `DPIO_PAGE_MAIN) begin
      case (s_axi_araddr)
        `DPIO_OFS_FIRST_DATA:   next_rdata[7:0] = first_read;
        `DPIO_OFS_FIRST_DIR:    next_rdata[7:0] = first_port_direction;
        `DPIO_OFS_FIRST_PULLUP: next_rdata[7:0] = first_port_pullup_enable;
        `DPIO_OFS_CHANGE_EN:    next_rdata[7:0] = {change_interrupt_enable, 4'h0}; // RULE7
        `DPIO_OFS_SECOND_DATA:  next_rdata[7:0] = second_read; // RULE4
        `DPIO_OFS_SECOND_DIR:   next_rdata[7:0] = second_port_direction;
        `DPIO_OFS_IRQ_CTRL:     next_rdata[7:0] = interrupt_control;
        `DPIO_OFS_OPTION:       next_rdata[7:0] = option_control;
        default:                next_rok = 1'b0;
      endcase
    end else if (s_axi_arpage == `DPIO_PAGE_LCD) begin
      case (s_axi_araddr)
        `DPIO_OFS_LCD_CTRL: next_rdata[7:0] = lcd_control;
        `DPIO_OFS_SEG_LOW:  next_rdata[7:0] = lcd_segment_enable_low;
        `DPIO_OFS_SEG_MID:  next_rdata[7:0] = lcd_segment_enable_mid;
        `DPIO_OFS_PERIPH:   next_rdata[7:0] = periph_select;
        default:            next_rok = 1'b0;
      endcase
    end else begin
      next_rok = 1'b0;
    end
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 5'h00;
      aw_page      <= 2'h0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= 2'h0;
      s_axi_rdata  <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        aw_page <= s_axi_awpage;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= next_rok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ordinary reset registers
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      first_port_direction     <= `DPIO_RST_FIRST_DIR; // RULE5
      first_port_pullup_enable <= `DPIO_RST_FIRST_PULLUP; // RULE6
      change_interrupt_enable  <= `DPIO_RST_CHANGE_EN; // RULE7
      second_port_direction    <= `DPIO_RST_SECOND_DIR;
      irq_ctrl_upper           <= 7'h00; // RULE8
      option_control           <= `DPIO_RST_OPTION; // RULE9
      lcd_control              <= `DPIO_RST_LCD_CTRL; // RULE14
      periph_select            <= `DPIO_RST_PERIPH;
      // reset selects rising edges; assume high so a pulled-up pin gives no false edge
      ext_pin_prev             <= 1'b1; // RULE10
    end else begin
      ext_pin_prev <= first_pin_in[0];
      if (wr_main) begin
        case (aw_addr)
          `DPIO_OFS_FIRST_DIR:    first_port_direction <= w_data[7:0];
          `DPIO_OFS_FIRST_PULLUP: first_port_pullup_enable <= w_data[7:0];
          `DPIO_OFS_CHANGE_EN:    change_interrupt_enable <= w_data[7:4]; // RULE7
          `DPIO_OFS_SECOND_DIR:   second_port_direction <= w_data[7:0]; // RULE3
          `DPIO_OFS_OPTION:       option_control <= w_data[7:0];
          default:                ;
        endcase
      end
      if (wr_lcd) begin
        case (aw_addr)
          `DPIO_OFS_LCD_CTRL: lcd_control <= w_data[7:0];
          `DPIO_OFS_PERIPH:   periph_select <= w_data[7:0];
          default:            ;
        endcase
      end
      // hardware set beats software clear for both flags
      irq_ctrl_upper[7:3] <= (wr_main && aw_addr == `DPIO_OFS_IRQ_CTRL) ?
        w_data[7:3] : interrupt_control[7:3]; // RULE8
      irq_ctrl_upper[2] <= timer0_overflow | ((wr_main && aw_addr == `DPIO_OFS_IRQ_CTRL) ?
        w_data[2] : interrupt_control[2]); // RULE8
      irq_ctrl_upper[1] <= ext_edge | ((wr_main && aw_addr == `DPIO_OFS_IRQ_CTRL) ?
        w_data[1] : interrupt_control[1]); // RULE10
    end
  end

  // change flag, latches and snapshot survive ordinary reset; flag cleared only by power reset
  always @(posedge clk_sys or posedge por_rst) begin
    if (por_rst) begin
      port_change_irq_flag   <= 1'b0;
      first_port_latch       <= 8'h00;
      second_port_latch      <= 8'h00;
      change_snapshot        <= 4'h0;
      lcd_segment_enable_low <= `DPIO_RST_SEG; // RULE15
      lcd_segment_enable_mid <= `DPIO_RST_SEG; // RULE15
    end else begin
      port_change_irq_flag <= (change_hit & ~sys_rst) | ((wr_main && aw_addr ==
        `DPIO_OFS_IRQ_CTRL) ? w_data[0] : interrupt_control[0]); // RULE8
      if ((wr_main || (rd_main && !sys_rst)) &&
          ((wr_main ? aw_addr : s_axi_araddr) == `DPIO_OFS_FIRST_DATA)) begin
        change_snapshot <= first_pin_in[7:4];
      end
      if (wr_main && aw_addr == `DPIO_OFS_FIRST_DATA) begin
        first_port_latch <= w_data[7:0];
      end
      if (wr_main && aw_addr == `DPIO_OFS_SECOND_DATA) begin
        second_port_latch <= w_data[7:0]; // RULE1 RULE2
      end
      if (wr_lcd && aw_addr == `DPIO_OFS_SEG_LOW) begin
        lcd_segment_enable_low <= w_data[7:0];
      end
      if (wr_lcd && aw_addr == `DPIO_OFS_SEG_MID) begin
        lcd_segment_enable_mid <= w_data[7:0];
      end
    end
  end

  wire unused_ok = rd_lcd;
endmodule // dpio_top

// ### test/dpio_chk.sv
// concurrent checks on the pin block's ports
module dpio_chk (
  input wire       clk_sys,
  input wire       sys_rst,
  input wire       s_axi_awvalid,
  input wire       s_axi_awready,
  input wire       s_axi_wvalid,
  input wire       s_axi_wready,
  input wire       s_axi_bvalid,
  input wire       s_axi_bready,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid,
  input wire       s_axi_rready,
  input wire [7:0] first_pin_in,
  input wire [7:0] first_pin_oe,
  input wire [7:0] first_pin_pullup,
  input wire [7:0] second_pin_in,
  input wire [7:0] second_pin_oe,
  input wire [7:0] lcd_analog_sel_first,
  input wire [7:0] lcd_analog_sel_second,
  input wire       ext_irq_event,
  input wire       timer1_clock_in,
  input wire       timer1_gate_in,
  input wire       capture_in,
  input wire       serial_program_clock,
  input wire       serial_program_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_write_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read response late");
  chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  chk_rresp_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped early");
  chk_reset_inputs: assert property ($fell(sys_rst) |-> first_pin_oe == 8'h00 &&
    second_pin_oe == 8'h00 && first_pin_pullup == 8'h00)
    else $error("pins not inputs after reset");
  chk_pullup_off: assert property ((first_pin_oe & first_pin_pullup) == 8'h00)
    else $error("pullup on a driven pin");
  chk_analog_quiet: assert property ((lcd_analog_sel_first & first_pin_oe) == 8'h00 &&
    (lcd_analog_sel_second & second_pin_oe) == 8'h00)
    else $error("driver on lcd analog pin");
  chk_timer_inputs: assert property (timer1_clock_in == second_pin_in[5] &&
    capture_in == second_pin_in[5] && timer1_gate_in == second_pin_in[4])
    else $error("timer input path wrong");
  chk_prog_pins: assert property (serial_program_clock == first_pin_in[6] &&
    serial_program_data == first_pin_in[7])
    else $error("programming pin path wrong");
  chk_edge_pulse: assert property (ext_irq_event |=> !ext_irq_event)
    else $error("edge event longer than a cycle");
endmodule // dpio_chk

bind dpio_top dpio_chk i_chk (.clk_sys, .sys_rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .first_pin_in, .first_pin_oe,
  .first_pin_pullup, .second_pin_in, .second_pin_oe, .lcd_analog_sel_first,
  .lcd_analog_sel_second, .ext_irq_event, .timer1_clock_in, .timer1_gate_in,
  .capture_in, .serial_program_clock, .serial_program_data);

// ### test/dpio_pin_board.sv
// board circuitry on one eight-pin port: drivers, pullups, floating pins
module dpio_pin_board (
  input  wire        clk_sys,
  input  wire  [7:0] pin_out,
  input  wire  [7:0] pin_oe,
  input  wire  [7:0] pin_pullup,
  input  wire  [7:0] ext_val,
  input  wire  [7:0] ext_en,
  output logic [7:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // a floating pin flips every cycle so a stale value never reads as valid
  logic [7:0] wander = 8'h55;
  always @(posedge clk_sys) begin
    wander <= ~wander;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i] && ext_en[i])
        pin_lvl[i] = 1'bx;
      else if (pin_oe[i])
        pin_lvl[i] = pin_out[i];
      else if (ext_en[i])
        pin_lvl[i] = ext_val[i];
      else if (pin_pullup[i])
        pin_lvl[i] = 1'b1;
      else
        pin_lvl[i] = wander[i];
    end
  end
endmodule // dpio_pin_board

// ### test/dpio_top_tb_top.sv
// self-checking bench for the dual port pin block
module dpio_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [1:0] pg; logic [4:0] a; logic wr; logic [7:0] d, exp;
    logic [1:0] rsp;} dpio_row_t;
  logic        clk_sys = 1'b0, sys_rst = 1'b1, por_rst = 1'b1, t0_ovf = 1'b0;
  logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [1:0]  s_axi_awpage = 2'h0, s_axi_arpage = 2'h0, s_axi_bresp, s_axi_rresp, rd_resp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_rready = 1'b0, s_axi_bvalid, s_axi_rvalid;
  logic        s_axi_awready, s_axi_wready, s_axi_arready, irq, edge_evt;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, rd_data;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [7:0]  p1_in, p1_out, p1_oe, p1_pu, p2_in, p2_out, p2_oe, sel1, sel2;
  logic [7:0]  ext1_val = 8'h00, ext1_en = 8'h01, ext2_val = 8'h00, ext2_en = 8'h00;
  logic [2:0]  bias_sel;
  int          num_errors = 0, n_checks = 0, n_edges = 0;
  dpio_row_t   rows[12] = '{
    '{2'h0, 5'h04, 1'h0, 8'h00, 8'hFF, 2'h0}, '{2'h0, 5'h08, 1'h0, 8'h00, 8'hFF, 2'h0},
    '{2'h0, 5'h0C, 1'h0, 8'h00, 8'h00, 2'h0}, '{2'h0, 5'h18, 1'h0, 8'h00, 8'h00, 2'h0},
    '{2'h0, 5'h1C, 1'h0, 8'h00, 8'hFF, 2'h0}, '{2'h0, 5'h14, 1'h0, 8'h00, 8'hFF, 2'h0},
    '{2'h1, 5'h08, 1'h0, 8'h00, 8'h13, 2'h0}, '{2'h1, 5'h0C, 1'h0, 8'h00, 8'h00, 2'h0},
    '{2'h0, 5'h0C, 1'h1, 8'hFF, 8'hF0, 2'h0}, '{2'h0, 5'h0C, 1'h1, 8'h0F, 8'h00, 2'h0},
    '{2'h1, 5'h10, 1'h1, 8'h5A, 8'h5A, 2'h0}, '{2'h2, 5'h00, 1'h1, 8'hFF, 8'h00, 2'h2}};
  always #4 clk_sys = ~clk_sys;
  always @(negedge clk_sys) begin
    if (edge_evt === 1'b1)
      n_edges++;
  end
  dpio_top i_dut (.clk_sys, .sys_rst, .por_rst, .s_axi_awaddr, .s_axi_awpage,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arpage, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .first_pin_in(p1_in), .first_pin_out(p1_out),
    .first_pin_oe(p1_oe), .first_pin_pullup(p1_pu), .second_pin_in(p2_in),
    .second_pin_out(p2_out), .second_pin_oe(p2_oe), .lcd_analog_sel_first(sel1),
    .lcd_analog_sel_second(sel2), .lcd_bias_input_sel(bias_sel), .ext_irq_event(edge_evt),
    .timer1_clock_in(), .timer1_gate_in(), .capture_compare_pwm_one_out(1'b0),
    .capture_in(), .serial_data_out(1'b0), .debugger_data_out(1'b0),
    .debugger_data_oe(1'b0), .serial_program_clock(), .serial_program_data(),
    .timer0_overflow(t0_ovf), .irq_request(irq));
  dpio_pin_board i_board_first (.clk_sys, .pin_out(p1_out), .pin_oe(p1_oe),
    .pin_pullup(p1_pu), .ext_val(ext1_val), .ext_en(ext1_en), .pin_lvl(p1_in));
  dpio_pin_board i_board_second (.clk_sys, .pin_out(p2_out), .pin_oe(p2_oe),
    .pin_pullup(8'h00), .ext_val(ext2_val), .ext_en(ext2_en), .pin_lvl(p2_in));
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic compare_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one transfer at a time; ready and answer are sampled mid-cycle to stay race free
  task automatic axi(input logic wr, input logic [1:0] pg, input logic [4:0] a,
    input logic [7:0] d);
    int n;
    logic ra, rw, rv;
    n = 0;
    s_axi_awpage <= pg;
    s_axi_awaddr <= a;
    s_axi_arpage <= pg;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_arvalid <= !wr;
    s_axi_bready <= wr;
    s_axi_rready <= !wr;
    do begin
      @(negedge clk_sys);
      ra = wr ? s_axi_awready : s_axi_arready;
      rw = s_axi_wready;
      rv = wr ? s_axi_bvalid : s_axi_rvalid;
      rd_data = s_axi_rdata;
      rd_resp = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge clk_sys);
      if (ra === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (ra === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (rw === 1'b1)
        s_axi_wvalid <= 1'b0;
      n++;
    end while (rv !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    // let the ready lines rest one edge before the next call raises them
    @(posedge clk_sys);
    if (rv !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
  endtask
  task automatic rchk(input string what, input logic [1:0] pg, input logic [4:0] a,
    input logic [7:0] exp);
    axi(1'b0, pg, a, 8'h00);
    compare_val(what, exp, rd_data[7:0]);
  endtask
  task automatic do_reset(input logic por);
    sys_rst <= 1'b1;
    por_rst <= por;
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic pin0_pulse(input logic [7:0] exp);
    n_edges = 0;
    ext1_val <= 8'h01;
    repeat (8) @(posedge clk_sys);
    ext1_val <= 8'h00;
    repeat (8) @(posedge clk_sys);
    compare_val("edge events", exp, n_edges[7:0]);
  endtask
  initial begin
    do_reset(1'b1);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axi(1'b1, rows[i].pg, rows[i].a, rows[i].d);
        compare_val("write response", {6'h00, rows[i].rsp}, {6'h00, rd_resp});
      end
      rchk("register", rows[i].pg, rows[i].a, rows[i].exp);
      compare_val("read response", {6'h00, rows[i].rsp}, {6'h00, rd_resp});
    end
    ext2_en <= 8'h0F;
    ext2_val <= 8'h5A;
    axi(1'b1, 2'h0, 5'h10, 8'hA5);
    axi(1'b1, 2'h0, 5'h14, 8'h0F);
    compare_val("second oe", 8'hF0, p2_oe);
    compare_val("second out", 8'hA0, p2_out & 8'hF0);
    rchk("second pins", 2'h0, 5'h10, 8'hAA);
    ext2_en <= 8'h00;
    axi(1'b1, 2'h0, 5'h14, 8'h00);
    axi(1'b1, 2'h0, 5'h10, 8'h3C);
    compare_val("second out", 8'h3C, p2_out);
    axi(1'b1, 2'h0, 5'h18, 8'hA0);
    t0_ovf <= 1'b1;
    @(posedge clk_sys);
    t0_ovf <= 1'b0;
    rchk("irq control", 2'h0, 5'h18, 8'hA4);
    compare_val("irq line", 8'h01, {7'h00, irq});
    axi(1'b1, 2'h0, 5'h04, 8'h0F);
    axi(1'b1, 2'h0, 5'h1C, 8'h7F);
    compare_val("pullups", 8'h0F, p1_pu);
    axi(1'b1, 2'h0, 5'h00, 8'hC3);
    compare_val("first out", 8'hC3, p1_out);
    pin0_pulse(8'h01);
    axi(1'b1, 2'h0, 5'h1C, 8'h3F);
    pin0_pulse(8'h01);
    axi(1'b1, 2'h0, 5'h14, 8'hFF);
    ext2_en <= 8'hFF;
    ext2_val <= 8'hFF;
    axi(1'b1, 2'h1, 5'h0C, 8'h4F);
    axi(1'b1, 2'h1, 5'h08, 8'h93);
    compare_val("bias select", 8'h01, {7'h00, bias_sel[1]});
    compare_val("analog first", 8'h3F, sel1 & 8'h3F);
    compare_val("analog second", 8'h08, sel2 & 8'h08);
    rchk("gated pin", 2'h0, 5'h10, 8'hFD);
    do_reset(1'b0);
    rchk("segments kept", 2'h1, 5'h0C, 8'h4F);
    rchk("lcd control", 2'h1, 5'h08, 8'h13);
    rchk("first dir", 2'h0, 5'h04, 8'hFF);
    do_reset(1'b1);
    rchk("segments cleared", 2'h1, 5'h0C, 8'h00);
    give_verdict();
  end
endmodule // dpio_top_tb_top
